// ==== rtl/dit_pkg.sv ====
/*
  Package for the down-counting interval timer: widths, reset values,
  status bit positions and the capture queue depth.
  Assumes a single 100 MHz clock domain and no register bus.
*/
package dit_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int DIT_RES = 16;
  localparam int DIT_QDEPTH = 4;
  localparam int DIT_QPTR = 2;
  localparam int DIT_NSTAT = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [DIT_RES-1:0] DIT_PERIOD_RST = 16'h00FF;
  localparam logic [DIT_NSTAT-1:0] DIT_MASK_RST = 4'h0;

  // ****************************************
  // status bit positions
  // ****************************************
  localparam int DIT_ST_TC = 0;
  localparam int DIT_ST_CAP = 1;
  localparam int DIT_ST_FULL = 2;
  localparam int DIT_ST_NEMP = 3;

  typedef enum logic [0:0] {
    DIT_IMPL_PROG = 1'b0,
    DIT_IMPL_FIXED = 1'b1
  } dit_impl_e;
endpackage

// ==== rtl/dit_timer.sv ====
/*
  Down-counting interval timer core with capture queue and a masked
  interrupt output. Control bits are plain ports driven by neighbouring
  logic; all inputs except arst_n are synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dit_timer
  import dit_pkg::*;
#(
  parameter dit_impl_e IMPL = DIT_IMPL_PROG
) (
  input wire logic clk, // 100 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic count_en, // counting enable
  input wire logic global_en, // global enable, fixed build only
  input wire logic reload_req, // external reload event
  input wire logic capture_req, // capture event
  input wire logic period_we, // period write strobe
  input wire logic [dit_pkg::DIT_RES-1:0] period_wdata, // new period
  input wire logic cap_rd, // pop one capture
  input wire logic [dit_pkg::DIT_NSTAT-1:0] int_mask, // per-bit mask
  input wire logic int_en, // auxiliary interrupt enable
  output logic [dit_pkg::DIT_RES-1:0] count, // live count
  output logic [dit_pkg::DIT_RES-1:0] period, // period register
  output logic [dit_pkg::DIT_RES-1:0] cap_data, // oldest capture; newest capture in the fixed build
  output logic [dit_pkg::DIT_NSTAT-1:0] status, // status bits
  output logic terminal_count, // pulse at zero, one cycle long unless period is 0
  output logic irq // interrupt output
);
  import dit_pkg::*;

  // ****************************************
  // enable and events
  // ****************************************
  logic run;
  logic at_zero;
  logic do_reload;
  logic [DIT_RES-1:0] q [DIT_QDEPTH];
  logic [DIT_QPTR-1:0] wr_ptr;
  logic [DIT_QPTR-1:0] rd_ptr;
  logic [DIT_QPTR:0] fill;
  logic push;
  logic pop;
  logic [DIT_RES-1:0] next_cap_data;
  logic [DIT_NSTAT-1:0] next_status;
  logic [DIT_RES-1:0] second_entry;

  assign run = count_en && (IMPL == DIT_IMPL_PROG || global_en);
  assign at_zero = (count == '0);
  assign do_reload = reload_req || (run && at_zero);

  // ****************************************
  // period register
  // ****************************************
  // writable period, param reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period <= DIT_PERIOD_RST;
    end else if (period_we) begin
      period <= period_wdata;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  // count, period and captures at DIT_RES bits; count is a plain output
  // reload wins over decrement; cycle starts at period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= DIT_PERIOD_RST;
    end else if (do_reload) begin
      count <= period;
    end else if (run) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      terminal_count <= 1'b0;
    end else begin
      terminal_count <= run && at_zero;
    end
  end

  // ****************************************
  // capture storage
  // ****************************************
  // fixed build keeps one register; a full queue drops new captures
  assign push = capture_req && (IMPL == DIT_IMPL_FIXED || fill != (DIT_QPTR+1)'(DIT_QDEPTH));
  assign pop = cap_rd && (fill != '0) && (IMPL == DIT_IMPL_PROG);

  // copy count on capture; in-order queue
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      for (int i = 0; i < DIT_QDEPTH; i++) begin
        q[i] <= '0;
      end
    end else begin
      if (push) begin
        q[wr_ptr] <= count;
        wr_ptr <= (IMPL == DIT_IMPL_FIXED) ? wr_ptr : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (IMPL == DIT_IMPL_FIXED) begin
        fill <= (push || fill != '0) ? (DIT_QPTR+1)'(1) : '0;
      end else begin
        fill <= fill + (DIT_QPTR+1)'(push) - (DIT_QPTR+1)'(pop);
      end
    end
  end

  // entry behind the head; it becomes the head after a pop
  assign second_entry = q[rd_ptr + 1'b1];

  // head of queue, registered so the port comes from a flip-flop
  always_comb begin
    next_cap_data = q[rd_ptr];
    if (fill == '0 || (pop && fill == (DIT_QPTR+1)'(1))) begin
      next_cap_data = push ? count : cap_data;
    end else if (pop) begin
      next_cap_data = second_entry;
    end
    // fixed build keeps a single register: the newest capture lands at once
    if (IMPL == DIT_IMPL_FIXED) begin
      next_cap_data = push ? count : cap_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_data <= '0;
    end else begin
      cap_data <= next_cap_data;
    end
  end

  // ****************************************
  // status and interrupt
  // ****************************************
  // tc source at zero; queue not empty
  always_comb begin
    next_status = '0;
    next_status[DIT_ST_TC] = run && at_zero;
    next_status[DIT_ST_CAP] = push;
    next_status[DIT_ST_FULL] = (IMPL == DIT_IMPL_PROG)
      && (fill + (DIT_QPTR+1)'(push) - (DIT_QPTR+1)'(pop) == (DIT_QPTR+1)'(DIT_QDEPTH));
    next_status[DIT_ST_NEMP] = (fill + (DIT_QPTR+1)'(push) - (DIT_QPTR+1)'(pop)) != '0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // per-bit mask; aux enable; OR of sources
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= int_en && |(next_status & int_mask);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_zero_run;
    run && at_zero && !reload_req;
  endsequence

  sequence s_reloaded;
    ##1 (count == $past(period)) && terminal_count;
  endsequence

  AST_DECREMENT: assert property (@(posedge clk) disable iff (!arst_n)
    run && !do_reload |=> count == $past(count) - 1'b1)
    else $error("count did not decrement");

  AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !run && !do_reload |=> $stable(count))
    else $error("count moved while stopped");

  AST_RELOAD: assert property (@(posedge clk) disable iff (!arst_n)
    reload_req |=> count == $past(period))
    else $error("reload did not load period");

  AST_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
    s_zero_run |-> s_reloaded)
    else $error("zero did not reload with pulse");

  AST_TC_ONE: assert property (@(posedge clk) disable iff (!arst_n)
    terminal_count && $past(period) != '0 |=> !terminal_count)
    else $error("terminal pulse too long");

  AST_GLOBAL: assert property (@(posedge clk) disable iff (!arst_n)
    IMPL == DIT_IMPL_FIXED && !global_en && !reload_req |=> $stable(count))
    else $error("fixed build ran without global enable");

  AST_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
    period_we |=> period == $past(period_wdata))
    else $error("period write lost");

  AST_CAPTURE: assert property (@(posedge clk) disable iff (!arst_n)
    capture_req && fill == '0 |=> cap_data == $past(count))
    else $error("capture did not copy count");

  AST_NEMP: assert property (@(posedge clk) disable iff (!arst_n)
    status[DIT_ST_NEMP] == (fill != '0))
    else $error("not-empty flag wrong");

  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(int_en) |-> !irq)
    else $error("interrupt without enable");

  AST_IRQ_OR: assert property (@(posedge clk) disable iff (!arst_n)
    int_en && int_mask[DIT_ST_TC] && run && at_zero |=> irq && status[DIT_ST_TC])
    else $error("tc interrupt missing");

  AST_MASK: assert property (@(posedge clk) disable iff (!arst_n)
    irq |-> |(status & $past(int_mask)))
    else $error("interrupt from masked source");

  AST_ORDER: assert property (@(posedge clk) disable iff (!arst_n)
    IMPL == DIT_IMPL_PROG && fill == (DIT_QPTR+1)'(2) && !push && cap_rd
      |=> cap_data == $past(second_entry))
    else $error("queue order broken");

  // ****************************************
  // queue, status, counter and interrupt checks
  // ****************************************
  // a pop that empties the queue with nothing arriving behind it
  sequence s_last_pop;
    IMPL == DIT_IMPL_PROG && fill == (DIT_QPTR+1)'(1) && cap_rd && !capture_req;
  endsequence

  // occupancy never passes the depth, so the pointers cannot overrun
  AST_FILL_MAX: assert property (@(posedge clk) disable iff (!arst_n)
    fill <= (DIT_QPTR+1)'(DIT_QDEPTH))
    else $error("queue overfilled");

  AST_FULL_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
    status[DIT_ST_FULL] == (IMPL == DIT_IMPL_PROG && fill == (DIT_QPTR+1)'(DIT_QDEPTH)))
    else $error("full flag wrong");

  // a full queue must drop the new entry rather than overwrite the oldest
  AST_FULL_DROP: assert property (@(posedge clk) disable iff (!arst_n)
    IMPL == DIT_IMPL_PROG && fill == (DIT_QPTR+1)'(DIT_QDEPTH) && capture_req |=> $stable(wr_ptr))
    else $error("capture written into a full queue");

  AST_HEAD_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    IMPL == DIT_IMPL_PROG && fill != '0 && !cap_rd |=> $stable(cap_data))
    else $error("queue head moved without a pop");

  AST_EMPTY_READ: assert property (@(posedge clk) disable iff (!arst_n)
    cap_rd && fill == '0 && !capture_req |=> fill == '0 && !status[DIT_ST_NEMP])
    else $error("read of an empty queue changed it");

  AST_DRAIN: assert property (@(posedge clk) disable iff (!arst_n)
    s_last_pop |=> fill == '0 && !status[DIT_ST_NEMP])
    else $error("not-empty flag stuck after last pop");

  AST_CAP_STATUS: assert property (@(posedge clk) disable iff (!arst_n)
    capture_req && (IMPL == DIT_IMPL_FIXED || fill != (DIT_QPTR+1)'(DIT_QDEPTH)) |=> status[DIT_ST_CAP])
    else $error("capture status missing");

  // the tc status bit and the tc port are two views of one event
  AST_TC_STATUS: assert property (@(posedge clk) disable iff (!arst_n)
    terminal_count == status[DIT_ST_TC])
    else $error("tc status and port disagree");

  AST_CYCLE_START: assert property (@(posedge clk) disable iff (!arst_n)
    do_reload |=> count == $past(period))
    else $error("cycle did not start at the period");

  // checked against the registered status, not the logic that feeds irq
  AST_IRQ_SRC: assert property (@(posedge clk) disable iff (!arst_n)
    $past(int_en) && |(status & $past(int_mask)) |-> irq)
    else $error("masked-in source gave no interrupt");

endmodule
`default_nettype wire

// ==== test/dit_soft_reader.sv ====
/*
  Polling software model: pops the capture queue while not empty.
  Assumes the queue-not-empty flag is a level.
*/
`timescale 1ns/1ns
`default_nettype none
module dit_soft_reader (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset
  input wire logic nemp, // queue not empty
  input wire logic slow, // stall this cycle
  output logic cap_rd // pop strobe
);
  // gap after each pop so the flag can settle, like a slow poll loop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_rd <= 1'b0;
    end else begin
      cap_rd <= nemp & ~slow & ~cap_rd;
    end
  end
endmodule
`default_nettype wire

// ==== test/down_counting_interval_timer_tb_top.sv ====
/*
  Bench for the timer: lfsr stimulus, queue-based model compared each cycle.
  Assumes the programmable build and single clock.
*/
`timescale 1ns/1ns
`default_nettype none
module down_counting_interval_timer_tb_top;
  import dit_pkg::*;
  logic clk, arst_n, count_en, global_en, reload_req, capture_req, period_we, cap_rd, int_en, slow, terminal_count, irq;
  logic [DIT_RES-1:0] period_wdata, count, period, cap_data, m_cnt, m_per;
  logic [DIT_NSTAT-1:0] int_mask, status, m_st;
  logic m_irq;
  logic [15:0] r;
  logic [DIT_RES-1:0] q[$];
  int mismatches, check_count, n;

  dit_timer u_dit_timer (.clk(clk), .arst_n(arst_n), .count_en(count_en), .global_en(global_en),
    .reload_req(reload_req), .capture_req(capture_req), .period_we(period_we), .period_wdata(period_wdata),
    .cap_rd(cap_rd), .int_mask(int_mask), .int_en(int_en), .count(count), .period(period),
    .cap_data(cap_data), .status(status), .terminal_count(terminal_count), .irq(irq));
  dit_soft_reader u_dit_soft_reader (.clk(clk), .arst_n(arst_n), .nemp(status[DIT_ST_NEMP]), .slow(slow),
    .cap_rd(cap_rd));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // model and stimulus
  // ****************************************
  // stimulus is drawn after the model steps, so gating sees settled state
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m_cnt = DIT_PERIOD_RST;
      m_per = DIT_PERIOD_RST;
      m_st = '0;
      m_irq = 1'b0;
      q.delete();
      r = 16'h004D;
      {count_en, global_en, reload_req, capture_req, period_we, int_en, slow} <= '0;
      period_wdata <= '0;
      int_mask <= '0;
    end else begin
      n = q.size();
      m_st = '0;
      if (cap_rd && n > 0) q.pop_front();
      // capture in order; a full queue drops the new entry
      if (capture_req && n < DIT_QDEPTH) begin
        q.push_back(m_cnt);
        m_st[DIT_ST_CAP] = 1'b1;
      end
      // count model; zero pulses even when a reload coincides
      if (count_en && m_cnt == 0) m_st[DIT_ST_TC] = 1'b1;
      if (reload_req || (count_en && m_cnt == 0)) begin
        m_cnt = m_per;
      end else if (count_en) begin
        m_cnt = m_cnt - 1'b1;
      end
      // a written period is seen from the next reload on
      if (period_we) m_per = period_wdata;
      m_st[DIT_ST_FULL] = (q.size() == DIT_QDEPTH);
      m_st[DIT_ST_NEMP] = (q.size() != 0);
      m_irq = int_en & |(m_st & int_mask);
      r = lfsr(r);
      count_en <= r[0] | r[1];
      global_en <= r[2];
      // reload at zero, writes during reload and captures into a full queue all occur
      reload_req <= r[3] & r[4] & r[5];
      capture_req <= r[6];
      period_we <= r[7] & r[2];
      period_wdata <= {12'h000, r[11:8]};
      int_mask <= r[15:12];
      int_en <= r[9] | r[10];
      slow <= r[14] & r[8];
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    check_count = 0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("count_rst", count, DIT_PERIOD_RST);
    check("period_rst", period, DIT_PERIOD_RST);
    repeat (3000) begin
      @(negedge clk);
      check("count", count, m_cnt);
      check("period", period, m_per);
      check("tc", terminal_count, m_st[DIT_ST_TC]);
      check("status", status, m_st);
      check("nemp", status[DIT_ST_NEMP], q.size() != 0);
      check("irq", irq, m_irq);
      if (q.size() > 0) check("cap_data", cap_data, q[0]);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
